// *** tb/tb_top.sv ***
// Self-checking bench: two-wire master against the monitor model
`timescale 1ns/100ps
`include "two_wire_master_regs.vh"
module tb_top;
   reg core_clk = 0;
   reg reset = 1;
   reg cmd_valid = 0;
   reg cmd_read = 0;
   reg cmd_with_pointer = 0;
   reg cmd_hs = 0;
   reg hs_seen = 0;
   reg [6:0] cmd_addr = 7'h00;
   reg [7:0] cmd_pointer = 8'h00;
   reg [7:0] cmd_len = 8'h00;
   reg [7:0] wr_data = 8'h00;
   reg [7:0] got [0:3];
   wire cmd_ready, wr_next, rd_valid, done, nack, hs_active;
   wire scl_out, scl_oe, sda_out, sda_oe, dev_sda_oe;
   wire [7:0] rd_data;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | dev_sda_oe);
   integer miscompares = 0;
   integer checks_done = 0;
   integer cycles = 0;
   integer nrd = 0;
   integer nwr = 0;
   always #4 core_clk = ~core_clk;
   two_wire_master i_two_wire_master (.core_clk(core_clk), .reset(reset),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_read(cmd_read),
      .cmd_with_pointer(cmd_with_pointer), .cmd_pointer(cmd_pointer), .cmd_len(cmd_len),
      .cmd_hs(cmd_hs), .wr_data(wr_data), .wr_next(wr_next), .rd_data(rd_data),
      .rd_valid(rd_valid), .done(done), .nack(nack), .hs_active(hs_active), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   temp_monitor_model #(.OWN_ADDR(`ADDR_PRESET_SECOND)) i_temp_monitor_model (.scl(scl),
      .sda(sda), .sda_oe(dev_sda_oe));
   task report_and_stop;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // Timeout well above the roughly 30000 cycles the tests need
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      // Per-command tallies restart when a command is taken
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
         nrd <= 0;
         nwr <= 0;
         hs_seen <= 1'b0;
      end
      if (rd_valid === 1'b1) begin
         got[nrd % 4] <= rd_data;
         nrd <= nrd + 1;
      end
      if (wr_next === 1'b1) nwr <= nwr + 1;
      if (hs_active === 1'b1) hs_seen <= 1'b1;
      if (cycles == 60000) begin
         miscompares = miscompares + 1;
         report_and_stop;
      end
   end
   task check(input string what, input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // Called at a falling edge; waits for ready, then for done
   task run_cmd(input [6:0] a, input r, input p, input [7:0] pt, input [7:0] n, input h);
      integer k;
      begin
         k = 0;
         while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k = k + 1;
         end
         cmd_addr = a;
         cmd_read = r;
         cmd_with_pointer = p;
         cmd_pointer = pt;
         cmd_len = n;
         cmd_hs = h;
         cmd_valid = 1;
         @(negedge core_clk);
         cmd_valid = 0;
         k = 0;
         while (done !== 1'b1 && k < 20000) begin
            @(negedge core_clk);
            k = k + 1;
         end
         check("done", {7'h00, done}, 8'h01);
      end
   endtask
   task t_write;
      begin
         wr_data = 8'h3C;
         run_cmd(`ADDR_PRESET_SECOND, 1'b0, 1'b0, 8'h21, 8'h01, 1'b0);
         check("nack", {7'h00, nack}, 8'h00);
         check("writes", nwr[7:0], 8'h01);
         $display("test write finished");
      end
   endtask
   task t_read_hs;
      begin
         run_cmd(`ADDR_PRESET_SECOND, 1'b1, 1'b1, 8'h20, 8'h02, 1'b1);
         check("reads", nrd[7:0], 8'h02);
         check("high byte", got[0], 8'h7A);
         check("low byte", got[1], 8'h3C);
         check("hs seen", {7'h00, hs_seen}, 8'h01);
         check("hs after stop", {7'h00, hs_active}, 8'h00);
         $display("test high-speed read finished");
      end
   endtask
   task t_read_again;
      begin
         run_cmd(`ADDR_PRESET_SECOND, 1'b1, 1'b0, 8'h00, 8'h01, 1'b0);
         check("reads", nrd[7:0], 8'h01);
         check("kept pointer", got[0], 8'h7A);
         check("idle", {6'h00, scl, sda}, 8'h03);
         $display("test repeated read finished");
      end
   endtask
   task t_wrong_addr;
      begin
         run_cmd(`ADDR_PRESET_FIRST, 1'b0, 1'b0, 8'h10, 8'h00, 1'b0);
         check("nack", {7'h00, nack}, 8'h01);
         run_cmd(`ADDR_PRESET_SECOND, 1'b1, 1'b0, 8'h00, 8'h01, 1'b0);
         check("nack cleared", {7'h00, nack}, 8'h00);
         check("pointer untouched", got[0], 8'h7A);
         $display("test wrong address finished");
      end
   endtask
   initial begin
      repeat (3) @(negedge core_clk);
      reset = 0;
      t_write;
      t_read_hs;
      t_read_again;
      t_wrong_addr;
      report_and_stop;
   end
endmodule

// *** tb/temp_monitor_model.sv ***
// Behavioural monitor slave: address match, pointer and register bytes
`timescale 1ns/100ps
`include "two_wire_master_regs.vh"
module temp_monitor_model #(
   parameter [6:0] OWN_ADDR = `ADDR_PRESET_SECOND
) (
   input wire scl,
   input wire sda,
   output reg sda_oe
);
   // Edge driven, so any SCL rate is taken
   reg [7:0] mem [0:255];
   reg [7:0] ptr;
   reg [7:0] sh;
   reg act;
   reg rd;
   integer bitn;
   integer nbyte;
   integer i;
   initial begin
      sda_oe = 0;
      act = 0;
      rd = 0;
      ptr = 8'h00;
      sh = 8'h00;
      bitn = 0;
      nbyte = 0;
      for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
   end
   // SDA edge with SCL high is control, never data
   always @(negedge sda) if (scl) begin
      act = 1;
      rd = 0;
      bitn = 0;
      nbyte = 0;
   end
   always @(posedge sda) if (scl) begin
      act = 0;
      sda_oe = 0;
   end
   always @(posedge scl) if (act) begin
      if (bitn < 8) sh = {sh[6:0], sda};
      else if (rd && sda) act = 0;
      bitn = bitn + 1;
   end
   always @(negedge scl) if (act) begin
      sda_oe = 0;
      if (bitn == 9) begin
         bitn = 0;
         nbyte = nbyte + 1;
      end
      if (bitn == 8 && nbyte == 0) begin
         if (sh[7:1] == OWN_ADDR) begin
            rd = sh[0];
            sda_oe = 1;
         end else if (sh[7:3] == 5'h01) sda_oe = 1;
         else act = 0;
      end else if (bitn == 8 && !rd) begin
         sda_oe = 1;
         if (nbyte == 1) ptr = sh;
         else mem[ptr] = sh;
      end else if (rd && bitn < 8) sda_oe = ~mem[ptr + nbyte - 1][7 - bitn];
   end
endmodule

// *** tb/two_wire_master_properties.sv ***
// Port-level timing properties of the two-wire master
`timescale 1ns/100ps
module two_wire_master_properties (
   input wire core_clk,
   input wire reset,
   input wire cmd_valid,
   input wire cmd_ready,
   input wire done,
   input wire nack,
   input wire hs_active,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_out,
   input wire sda_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // SDA pulled or released while SCL is released
   sequence s_start;
      $rose(sda_oe) && !scl_oe;
   endsequence
   sequence s_stop;
      $fell(sda_oe) && !scl_oe;
   endsequence
   a_open_drain: assert property (!scl_out && !sda_out)
      else $error("line driven high");
   a_idle_free: assert property (cmd_ready |-> !scl_oe && !sda_oe)
      else $error("bus held while idle");
   a_start_clock: assert property (s_start |-> ##[1:100] scl_oe)
      else $error("no clock after start");
   a_stop_done: assert property (s_stop |-> ##[1:100] done)
      else $error("stop without done");
   a_sda_apart: assert property ($changed(sda_oe) |-> $stable(scl_oe))
      else $error("sda and scl moved together");
   a_data_settled: assert property ($changed(sda_oe) && scl_oe |-> $past(scl_oe, 8))
      else $error("sda moved too soon after scl fell");
   a_low_period: assert property ($rose(scl_oe) |=> scl_oe [*8])
      else $error("scl low too short");
   a_high_period: assert property ($fell(scl_oe) |=> !scl_oe [*8])
      else $error("scl high too short");
   a_nack_stop: assert property ($rose(nack) |-> ##[1:1000] done)
      else $error("no stop after nack");
   a_hs_end: assert property (done |=> !hs_active)
      else $error("fast timing kept after stop");
   a_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready kept after command");
endmodule
bind two_wire_master two_wire_master_properties i_two_wire_master_properties (
   .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .done(done), .nack(nack), .hs_active(hs_active), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_out(sda_out), .sda_oe(sda_oe)
);

// *** verilog/pin_sync.v ***
// Three-stage synchroniser with agreement filter for one bus pin
`timescale 1ns/100ps
module pin_sync #(
   parameter RESET_LEVEL = 1'b1
) (
   input wire core_clk,
   input wire reset,
   input wire pin,
   output reg level
);
   reg meta;
   reg stage2;
   reg stage3;

   always @(posedge core_clk) begin
      if (reset) begin
         meta <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
         level <= RESET_LEVEL;
      end else begin
         meta <= pin;
         stage2 <= meta;
         stage3 <= stage2;
         // Only a level seen twice counts, which rejects single-cycle spikes
         if (stage2 == stage3) begin
            level <= stage3;
         end
      end
   end
endmodule

// *** verilog/two_wire_master.v ***
// Two-wire bus master: pointer writes, data writes and reads on the monitor
`timescale 1ns/100ps
`include "two_wire_master_regs.vh"
module two_wire_master #(
   parameter LEN_W = 8,
   parameter HS_CODE_LOW = 3'h0
) (
   input wire core_clk,
   input wire reset,
   input wire cmd_valid,
   output reg cmd_ready,
   input wire [6:0] cmd_addr,
   input wire cmd_read,
   input wire cmd_with_pointer,
   input wire [7:0] cmd_pointer,
   input wire [LEN_W-1:0] cmd_len,
   input wire cmd_hs,
   input wire [7:0] wr_data,
   output reg wr_next,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg done,
   output reg nack,
   output reg hs_active,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe
);
   localparam integer FAST_QI = `FAST_QTR_CYC - 1;
   localparam integer HS_QI = `HS_QTR_CYC - 1;
   localparam [7:0] FAST_Q = FAST_QI[7:0];
   localparam [7:0] HS_Q = HS_QI[7:0];
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_START = 5'h02;
   localparam [4:0] ST_BYTE = 5'h04;
   localparam [4:0] ST_STOP = 5'h08;
   localparam [2:0] K_HS = 3'h0;
   localparam [2:0] K_ADDR = 3'h1;
   localparam [2:0] K_PTR = 3'h2;
   localparam [2:0] K_WDATA = 3'h3;
   localparam [2:0] K_RDATA = 3'h4;
   localparam [LEN_W-1:0] LEN_ONE = {{(LEN_W-1){1'b0}}, 1'b1};
   localparam [LEN_W-1:0] LEN_ZERO = {LEN_W{1'b0}};

   reg [4:0] state;
   reg [2:0] kind;
   reg [1:0] qtr;
   reg [7:0] cnt;
   reg [3:0] bit_idx;
   reg [7:0] shreg;
   reg ack_seen;
   reg dir;
   reg [6:0] addr;
   reg want_read;
   reg [7:0] pointer;
   reg [LEN_W-1:0] remain;
   wire scl_level;
   wire sda_level;
   wire stall;
   wire tick;

   pin_sync #(.RESET_LEVEL(1'b1)) scl_sync (
      .core_clk(core_clk),
      .reset(reset),
      .pin(scl_in),
      .level(scl_level)
   );

   pin_sync #(.RESET_LEVEL(1'b1)) sda_sync (
      .core_clk(core_clk),
      .reset(reset),
      .pin(sda_in),
      .level(sda_level)
   );

   // Waiting for SCL to read high lets a slow line or a stretching slave finish rising
   assign stall = (qtr == `QTR_SAMPLE) && !scl_oe && !scl_level;
   assign tick = (state != ST_IDLE) && (cnt == 8'h00) && !stall;

   // Address byte, then direction in the last bit
   function [7:0] addr_byte;
      input [6:0] a;
      input d;
      begin
         addr_byte = {a, d};
      end
   endfunction

   always @(posedge core_clk) begin
      if (reset || state == ST_IDLE) begin
         cnt <= FAST_Q;
      end else if (tick) begin
         cnt <= hs_active ? HS_Q : FAST_Q;
      end else if (!stall) begin
         cnt <= cnt - 8'h01;
      end
   end

   always @(posedge core_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         kind <= K_ADDR;
         qtr <= 2'h0;
         bit_idx <= 4'h0;
         shreg <= `BYTE_IDLE;
         ack_seen <= 1'b1;
         dir <= `DIR_WRITE;
         addr <= 7'h00;
         want_read <= 1'b0;
         pointer <= 8'h00;
         remain <= LEN_ZERO;
         cmd_ready <= 1'b0;
         wr_next <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         hs_active <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         wr_next <= 1'b0;
         rd_valid <= 1'b0;
         done <= 1'b0;
         if (tick) begin
            qtr <= qtr + `QTR_INC;
         end
         case (state)
            ST_IDLE: begin
               qtr <= 2'h0;
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  nack <= 1'b0;
                  addr <= cmd_addr;
                  want_read <= cmd_read;
                  pointer <= cmd_pointer;
                  remain <= cmd_len;
                  // Reads with a new pointer go out as a write first
                  dir <= (cmd_read && !cmd_with_pointer) ? `DIR_READ : `DIR_WRITE;
                  kind <= cmd_hs ? K_HS : K_ADDR;
                  state <= ST_START;
               end
            end
            ST_START: begin
               if (tick) begin
                  case (qtr)
                     `QTR_SET_SDA: sda_oe <= 1'b0;
                     `QTR_RISE: scl_oe <= 1'b0;
                     `QTR_SAMPLE: sda_oe <= 1'b1;
                     default: begin
                        scl_oe <= 1'b1;
                        bit_idx <= 4'h0;
                        shreg <= (kind == K_HS) ? {`HS_CODE_TOP, HS_CODE_LOW} :
                           addr_byte(addr, dir);
                        state <= ST_BYTE;
                     end
                  endcase
               end
            end
            ST_BYTE: begin
               if (tick) begin
                  case (qtr)
                     `QTR_SET_SDA: begin
                        // SDA moves only in the low half of the clock
                        if (bit_idx != `ACK_BIT) begin
                           sda_oe <= ~shreg[7];
                        end else begin
                           sda_oe <= (kind == K_RDATA) && (remain != LEN_ONE);
                        end
                     end
                     `QTR_RISE: scl_oe <= 1'b0;
                     `QTR_SAMPLE: begin
                        if (bit_idx != `ACK_BIT) begin
                           shreg <= {shreg[6:0], sda_level};
                        end else begin
                           ack_seen <= sda_level;
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        if (bit_idx != `ACK_BIT) begin
                           bit_idx <= bit_idx + `BIT_INC;
                        end else begin
                           // SDA waits for the next quarter; moving it with SCL could fake a stop
                           bit_idx <= 4'h0;
                           case (kind)
                              K_HS: begin
                                 // The master code may go unanswered; the switch holds anyway
                                 hs_active <= 1'b1;
                                 kind <= K_ADDR;
                                 state <= ST_START;
                              end
                              K_ADDR: begin
                                 if (ack_seen) begin
                                    nack <= 1'b1;
                                    state <= ST_STOP;
                                 end else if (dir == `DIR_WRITE) begin
                                    kind <= K_PTR;
                                    shreg <= pointer;
                                 end else if (remain != LEN_ZERO) begin
                                    kind <= K_RDATA;
                                    shreg <= `BYTE_IDLE;
                                 end else begin
                                    state <= ST_STOP;
                                 end
                              end
                              K_PTR: begin
                                 if (ack_seen) begin
                                    nack <= 1'b1;
                                    state <= ST_STOP;
                                 end else if (want_read) begin
                                    dir <= `DIR_READ;
                                    kind <= K_ADDR;
                                    state <= ST_START;
                                 end else if (remain != LEN_ZERO) begin
                                    kind <= K_WDATA;
                                    shreg <= wr_data;
                                    wr_next <= 1'b1;
                                 end else begin
                                    state <= ST_STOP;
                                 end
                              end
                              K_WDATA: begin
                                 remain <= remain - LEN_ONE;
                                 if (ack_seen) begin
                                    nack <= 1'b1;
                                    state <= ST_STOP;
                                 end else if (remain != LEN_ONE) begin
                                    shreg <= wr_data;
                                    wr_next <= 1'b1;
                                 end else begin
                                    state <= ST_STOP;
                                 end
                              end
                              default: begin
                                 rd_data <= shreg;
                                 rd_valid <= 1'b1;
                                 remain <= remain - LEN_ONE;
                                 shreg <= `BYTE_IDLE;
                                 if (remain == LEN_ONE) begin
                                    state <= ST_STOP;
                                 end
                              end
                           endcase
                        end
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (tick) begin
                  case (qtr)
                     `QTR_SET_SDA: sda_oe <= 1'b1;
                     `QTR_RISE: scl_oe <= 1'b0;
                     `QTR_SAMPLE: sda_oe <= 1'b0;
                     default: begin
                        // Last quarter doubles as bus free time before the next start
                        hs_active <= 1'b0;
                        done <= 1'b1;
                        state <= ST_IDLE;
                     end
                  endcase
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** verilog/two_wire_master_regs.vh ***
// Constants for the two-wire bus master that drives the temperature monitor
`ifndef TWO_WIRE_MASTER_REGS_VH
`define TWO_WIRE_MASTER_REGS_VH

// Core clock period
`define CLK_NS 8
// Quarter of an SCL period, fast mode (400 kHz) and high-speed mode
`define FAST_QTR_NS 625
`define HS_QTR_NS 80
// Least times round up to whole clock cycles
`define FAST_QTR_CYC ((`FAST_QTR_NS + `CLK_NS - 1) / `CLK_NS)
`define HS_QTR_CYC ((`HS_QTR_NS + `CLK_NS - 1) / `CLK_NS)

// High-speed master code, upper five bits fixed
`define HS_CODE_TOP 5'h01
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define ACK_BIT 4'h8
`define BIT_INC 4'h1
`define QTR_INC 2'h1
`define QTR_SET_SDA 2'h0
`define QTR_RISE 2'h1
`define QTR_SAMPLE 2'h2
`define QTR_FALL 2'h3
`define BYTE_IDLE 8'hFF

// Target addresses of the monitor variants
`define ADDR_PIN_LOW_LOW 7'h4C
`define ADDR_PIN_HIGH_HIGH 7'h4F
`define ADDR_PIN_FLOAT_FLOAT 7'h2A
`define ADDR_PIN_FLOAT_LOW 7'h1C
`define ADDR_PRESET_FIRST 7'h4C
`define ADDR_PRESET_SECOND 7'h4D

`endif
